// ===== hdl/lhci_pkg.sv
// Purpose: Shared constants for the display controller host command interface.
// Assumes: Command bytes are 8 bits; link straps are sampled through synchronisers.
// Notes: Opcodes are given as a mask and a match value each.
package lhci_pkg;

  // ----------------------------------------------------------------
  // Link selection by the three mode straps {sel_2, sel_1, sel_0}.
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_SPI = 3'h0;
  localparam logic [2:0] MODE_I2C = 3'h5;
  localparam logic [2:0] MODE_PAR_STROBES = 3'h6;
  localparam logic [2:0] MODE_PAR_ENABLE = 3'h7;

  // ----------------------------------------------------------------
  // Command opcodes as mask and match value.
  // ----------------------------------------------------------------
  localparam logic [7:0] MSK_NIB = 8'hF0;
  localparam logic [7:0] MSK_ALL = 8'hFF;
  localparam logic [7:0] MSK_B0 = 8'hFE;
  localparam logic [7:0] MSK_B10 = 8'hFC;
  localparam logic [7:0] OP_COL_LO = 8'h00;
  localparam logic [7:0] OP_COL_HI = 8'h10;
  localparam logic [7:0] MSK_SCROLL = 8'hC0;
  localparam logic [7:0] OP_SCROLL = 8'h40;
  localparam logic [7:0] OP_PAGE = 8'hB0;
  localparam logic [7:0] OP_CONTRAST = 8'h81;
  localparam logic [7:0] OP_PARTIAL = 8'h84;
  localparam logic [7:0] MSK_ADV = 8'hF8;
  localparam logic [7:0] OP_ADV = 8'h88;
  localparam logic [7:0] OP_FRAME = 8'hA0;
  localparam logic [7:0] OP_ALLON = 8'hA4;
  localparam logic [7:0] OP_INVERT = 8'hA6;
  localparam logic [7:0] OP_DISPLAY = 8'hAE;
  localparam logic [7:0] MSK_SCAN = 8'hF9;
  localparam logic [7:0] OP_SCAN = 8'hC0;
  localparam logic [7:0] OP_SOFT_RESET = 8'hE2;
  localparam logic [7:0] OP_NOP = 8'hE3;
  localparam logic [7:0] OP_BIAS = 8'hE8;
  localparam logic [7:0] OP_TEST = 8'hF0;
  localparam logic [7:0] OP_COM_END = 8'hF1;
  localparam logic [7:0] OP_PART_START = 8'hF2;
  localparam logic [7:0] OP_PART_END = 8'hF3;

  // ----------------------------------------------------------------
  // Reset values of the settings.
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CONTRAST = 8'h00;
  localparam logic [5:0] RST_COM_END = 6'h3F;
  localparam logic [5:0] RST_PART_START = 6'h00;
  localparam logic [5:0] RST_PART_END = 6'h3F;
  localparam logic [2:0] RST_ADV = 3'h0;
  localparam logic [1:0] RST_BIAS = 2'h0;
  localparam logic [1:0] RST_FRAME = 2'h0;

  // ----------------------------------------------------------------
  // Identity and serial constants. The chip ID and I2C address below are arbitrary.
  // ----------------------------------------------------------------
  localparam logic [2:0] CHIP_ID = 3'h5;
  localparam logic [6:0] I2C_ADDR = 7'h3C;
  localparam logic [3:0] I2C_LAST_BIT = 4'h7;
  localparam logic [3:0] I2C_ACK_BIT = 4'h8;
  localparam logic [3:0] I2C_ACK_END = 4'h9;
  localparam logic [2:0] SPI_LAST_BIT = 3'h7;

  // Pending second byte of a two-byte command.
  typedef enum logic [2:0] {
    ARG_NONE = 3'b000,
    ARG_CONTRAST = 3'b001,
    ARG_COM_END = 3'b011,
    ARG_PART_START = 3'b010,
    ARG_PART_END = 3'b110
  } lhci_arg_t;

  typedef enum logic [1:0] {
    I2C_IDLE = 2'b00,
    I2C_ADDRESS = 2'b01,
    I2C_WRITE = 2'b11,
    I2C_READ = 2'b10
  } lhci_i2c_t;

endpackage

// ===== hdl/lhci_top.sv
// Purpose: Host link and command decoder of a 192x64 graphic display controller.
// Assumes: All host link pins are asynchronous to clk and pass a two-flop synchroniser.
// Notes: Display RAM itself lies outside; this block issues its writes and reads.
`timescale 1ns/1ps

module lhci_top (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Host link pins
  input wire logic bus_mode_sel_0,
  input wire logic bus_mode_sel_1,
  input wire logic bus_mode_sel_2,
  input wire logic chip_select_n,
  input wire logic cmd_data_select,
  input wire logic read_or_enable_strobe,
  input wire logic write_or_direction_strobe,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic [7:0] data_oe,
  // Status inputs from the display engine
  input wire logic status_flag_bit4,
  input wire logic status_flag_bit3,
  // Display RAM port
  output logic ram_wr_en,
  output logic [7:0] ram_wr_data,
  input wire logic [7:0] ram_rd_data,
  // Settings
  output logic [7:0] column_addr,
  output logic [3:0] page_addr,
  output logic [5:0] start_line,
  output logic [7:0] contrast_value,
  output logic partial_enable,
  output logic [2:0] addr_advance_ctrl,
  output logic [1:0] frame_rate_sel,
  output logic all_pixels_on,
  output logic invert_display,
  output logic display_on_not_powerdown,
  output logic com_mirror,
  output logic seg_mirror,
  output logic [1:0] bias_ratio,
  output logic [5:0] com_end_line,
  output logic [5:0] partial_start_line,
  output logic [5:0] partial_end_line,
  output logic test_table_sel,
  output logic soft_reset_pulse
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic op_is(input logic [7:0] b, input logic [7:0] m, input logic [7:0] v);
    op_is = (b & m) == v;
  endfunction

  function automatic logic [7:0] read_value(input logic dc, input logic second,
                                            input logic [7:0] ram, input logic f4,
                                            input logic f3, input logic sm, input logic cm);
    if (dc)
      read_value = ram;
    else if (second)
      read_value = {6'h00, lhci_pkg::CHIP_ID[2:1]};
    else
      read_value = {lhci_pkg::CHIP_ID[0], sm, cm, f4, f3, 3'h0};
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers and edge history
  // ----------------------------------------------------------------
  localparam int PW = 15;
  logic [PW-1:0] pin_raw;
  logic [PW-1:0] sync1;
  logic [PW-1:0] sync2;
  logic [PW-1:0] hist;

  assign pin_raw = {bus_mode_sel_2, bus_mode_sel_1, bus_mode_sel_0, chip_select_n,
                    cmd_data_select, read_or_enable_strobe, write_or_direction_strobe,
                    data_in};

  always_ff @(posedge clk) begin
    if (reset) begin
      sync1 <= {PW{1'b1}};
      sync2 <= {PW{1'b1}};
      hist <= {PW{1'b1}};
    end else begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      hist <= sync2;
    end
  end

  wire [2:0] mode = sync2[14:12];
  wire cs_on = ~sync2[11];
  wire dc = sync2[10];
  wire rd_now = sync2[9];
  wire rd_was = hist[9];
  wire wr_now = sync2[8];
  wire wr_was = hist[8];
  wire [7:0] bus_was = hist[7:0];
  wire dc_was = hist[10];
  wire scl_now = sync2[0];
  wire scl_was = hist[0];
  wire sda_now = sync2[1];
  wire sda_was = hist[1];

  wire mode_spi = mode == lhci_pkg::MODE_SPI;
  wire mode_i2c = mode == lhci_pkg::MODE_I2C;
  wire mode_pst = mode == lhci_pkg::MODE_PAR_STROBES;
  wire mode_pen = mode == lhci_pkg::MODE_PAR_ENABLE;
  wire mode_par = mode_pst | mode_pen;

  // ----------------------------------------------------------------
  // Parallel bus
  // ----------------------------------------------------------------
  // Strobe style takes a write on the rising edge of the write strobe; enable style
  // takes it on the falling edge of enable with direction low.
  wire pst_wr = mode_pst & cs_on & wr_now & ~wr_was;
  wire pen_wr = mode_pen & cs_on & ~rd_now & rd_was & ~wr_was;
  wire par_take = pst_wr | pen_wr;
  wire pst_rd = mode_pst & cs_on & ~rd_now;
  wire pen_rd = mode_pen & cs_on & rd_now & wr_now;
  wire par_rd_active = pst_rd | pen_rd;
  wire pst_rd_end = mode_pst & cs_on & rd_now & ~rd_was;
  wire pen_rd_end = mode_pen & cs_on & ~rd_now & rd_was & wr_was;
  wire par_rd_end = pst_rd_end | pen_rd_end;

  // ----------------------------------------------------------------
  // Four-line serial, write only
  // ----------------------------------------------------------------
  logic [6:0] spi_shift;
  logic [2:0] spi_count;
  wire spi_rise = mode_spi & cs_on & scl_now & ~scl_was;
  wire spi_take = spi_rise & (spi_count == lhci_pkg::SPI_LAST_BIT);

  always_ff @(posedge clk) begin
    if (reset || !cs_on) begin
      spi_shift <= 7'h00;
      spi_count <= 3'h0;
    end else if (spi_rise) begin
      spi_shift <= {spi_shift[5:0], sda_now};
      spi_count <= spi_count + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // I2C slave
  // ----------------------------------------------------------------
  lhci_pkg::lhci_i2c_t i2c_state;
  logic [7:0] i2c_shift;
  logic [3:0] i2c_count;
  logic [7:0] i2c_tx;
  logic i2c_addr_ok;
  logic i2c_rw;
  logic sda_low;
  logic status_second;
  wire i2c_on = mode_i2c & cs_on;
  wire i2c_start = i2c_on & scl_now & scl_was & sda_was & ~sda_now;
  wire i2c_stop = i2c_on & scl_now & scl_was & ~sda_was & sda_now;
  wire i2c_rise = i2c_on & scl_now & ~scl_was & (i2c_state != lhci_pkg::I2C_IDLE);
  wire i2c_fall = i2c_on & ~scl_now & scl_was & (i2c_state != lhci_pkg::I2C_IDLE);
  wire i2c_byte = i2c_rise & (i2c_count == lhci_pkg::I2C_LAST_BIT);
  wire [7:0] i2c_rx = {i2c_shift[6:0], sda_now};
  wire i2c_take = i2c_byte & (i2c_state == lhci_pkg::I2C_WRITE);
  wire i2c_rd_ack = i2c_rise & (i2c_count == lhci_pkg::I2C_ACK_BIT);
  wire i2c_rd_end = i2c_rd_ack & (i2c_state == lhci_pkg::I2C_READ);
  wire i2c_load = i2c_fall & (i2c_count == lhci_pkg::I2C_ACK_END);
  wire [7:0] rd_byte = read_value(dc, status_second, ram_rd_data, status_flag_bit4,
                                  status_flag_bit3, seg_mirror, com_mirror);
  wire [2:0] tx_bit = 3'h7 - i2c_count[2:0];

  always_ff @(posedge clk) begin
    if (reset || !i2c_on || i2c_stop) begin
      i2c_state <= lhci_pkg::I2C_IDLE;
      i2c_count <= 4'h0;
      sda_low <= 1'b0;
    end else if (i2c_start) begin
      i2c_state <= lhci_pkg::I2C_ADDRESS;
      i2c_count <= 4'h0;
      sda_low <= 1'b0;
    end else if (i2c_rise) begin
      i2c_count <= i2c_count + 4'h1;
      if (i2c_rd_end && sda_now)
        i2c_state <= lhci_pkg::I2C_IDLE;
    end else if (i2c_fall) begin
      if (i2c_count == lhci_pkg::I2C_ACK_BIT) begin
        sda_low <= (i2c_state == lhci_pkg::I2C_ADDRESS) ? i2c_addr_ok
                 : (i2c_state == lhci_pkg::I2C_WRITE);
      end else if (i2c_load) begin
        i2c_count <= 4'h0;
        if (i2c_state == lhci_pkg::I2C_ADDRESS && !i2c_addr_ok)
          i2c_state <= lhci_pkg::I2C_IDLE;
        else if (i2c_state == lhci_pkg::I2C_ADDRESS)
          i2c_state <= i2c_rw ? lhci_pkg::I2C_READ : lhci_pkg::I2C_WRITE;
        sda_low <= (i2c_rw && i2c_addr_ok) ? ~rd_byte[7] : 1'b0;
      end else if (i2c_state == lhci_pkg::I2C_READ) begin
        sda_low <= ~i2c_tx[tx_bit];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      i2c_shift <= 8'h00;
      i2c_tx <= 8'h00;
      i2c_addr_ok <= 1'b0;
      i2c_rw <= 1'b0;
    end else begin
      if (i2c_rise)
        i2c_shift <= i2c_rx;
      if (i2c_byte && i2c_state == lhci_pkg::I2C_ADDRESS) begin
        i2c_addr_ok <= i2c_rx[7:1] == lhci_pkg::I2C_ADDR;
        i2c_rw <= i2c_rx[0];
      end
      if (i2c_load)
        i2c_tx <= rd_byte;
    end
  end

  // ----------------------------------------------------------------
  // Byte merge and read bookkeeping
  // ----------------------------------------------------------------
  wire byte_take = par_take | spi_take | i2c_take;
  wire [7:0] byte_val = par_take ? bus_was : spi_take ? {spi_shift, sda_now} : i2c_rx;
  wire byte_dc = par_take ? dc_was : dc;
  wire cmd_take = byte_take & ~byte_dc;
  wire rd_end = par_rd_end | i2c_rd_end;
  wire rd_end_dc = par_rd_end ? dc_was : dc;

  always_ff @(posedge clk) begin
    if (reset || byte_take)
      status_second <= 1'b0;
    else if (par_rd_end && !dc_was)
      status_second <= ~status_second;
  end

  // ----------------------------------------------------------------
  // Command decoder
  // ----------------------------------------------------------------
  lhci_pkg::lhci_arg_t arg_state;
  wire in_arg = arg_state != lhci_pkg::ARG_NONE;
  wire new_cmd = cmd_take & ~in_arg;
  wire arg_take = cmd_take & in_arg;
  wire c_col_lo = new_cmd & op_is(byte_val, lhci_pkg::MSK_NIB, lhci_pkg::OP_COL_LO);
  wire c_col_hi = new_cmd & op_is(byte_val, lhci_pkg::MSK_NIB, lhci_pkg::OP_COL_HI);
  wire c_scroll = new_cmd & op_is(byte_val, lhci_pkg::MSK_SCROLL, lhci_pkg::OP_SCROLL);
  wire c_page = new_cmd & op_is(byte_val, lhci_pkg::MSK_NIB, lhci_pkg::OP_PAGE);
  wire c_contr = new_cmd & op_is(byte_val, lhci_pkg::MSK_ALL, lhci_pkg::OP_CONTRAST);
  wire c_part = new_cmd & op_is(byte_val, lhci_pkg::MSK_B0, lhci_pkg::OP_PARTIAL);
  wire c_adv = new_cmd & op_is(byte_val, lhci_pkg::MSK_ADV, lhci_pkg::OP_ADV);
  wire c_frame = new_cmd & op_is(byte_val, lhci_pkg::MSK_B10, lhci_pkg::OP_FRAME);
  wire c_allon = new_cmd & op_is(byte_val, lhci_pkg::MSK_B0, lhci_pkg::OP_ALLON);
  wire c_inv = new_cmd & op_is(byte_val, lhci_pkg::MSK_B0, lhci_pkg::OP_INVERT);
  wire c_disp = new_cmd & op_is(byte_val, lhci_pkg::MSK_B0, lhci_pkg::OP_DISPLAY);
  wire c_scan = new_cmd & op_is(byte_val, lhci_pkg::MSK_SCAN, lhci_pkg::OP_SCAN);
  wire c_srst = new_cmd & op_is(byte_val, lhci_pkg::MSK_ALL, lhci_pkg::OP_SOFT_RESET);
  wire c_bias = new_cmd & op_is(byte_val, lhci_pkg::MSK_B10, lhci_pkg::OP_BIAS);
  wire c_test = new_cmd & op_is(byte_val, lhci_pkg::MSK_ALL, lhci_pkg::OP_TEST);
  wire c_cend = new_cmd & op_is(byte_val, lhci_pkg::MSK_ALL, lhci_pkg::OP_COM_END);
  wire c_pst = new_cmd & op_is(byte_val, lhci_pkg::MSK_ALL, lhci_pkg::OP_PART_START);
  wire c_pend = new_cmd & op_is(byte_val, lhci_pkg::MSK_ALL, lhci_pkg::OP_PART_END);
  wire data_wr = byte_take & byte_dc;
  wire data_rd = rd_end & rd_end_dc;
  wire any_reset = reset | c_srst;

  always_ff @(posedge clk) begin
    if (reset)
      arg_state <= lhci_pkg::ARG_NONE;
    else if (arg_take)
      arg_state <= lhci_pkg::ARG_NONE;
    else if (c_contr)
      arg_state <= lhci_pkg::ARG_CONTRAST;
    else if (c_cend)
      arg_state <= lhci_pkg::ARG_COM_END;
    else if (c_pst)
      arg_state <= lhci_pkg::ARG_PART_START;
    else if (c_pend)
      arg_state <= lhci_pkg::ARG_PART_END;
  end

  // Undefined bytes match no decode term and change nothing.
  always_ff @(posedge clk) begin
    if (any_reset) begin
      column_addr <= 8'h00;
      page_addr <= 4'h0;
      start_line <= 6'h00;
    end else begin
      if (c_col_lo)
        column_addr[3:0] <= byte_val[3:0];
      else if (c_col_hi)
        column_addr[7:4] <= byte_val[3:0];
      else if (data_wr || data_rd)
        column_addr <= column_addr + 8'h01;
      if (c_page)
        page_addr <= byte_val[3:0];
      if (c_scroll)
        start_line <= byte_val[5:0];
    end
  end

  always_ff @(posedge clk) begin
    if (any_reset) begin
      contrast_value <= lhci_pkg::RST_CONTRAST;
      com_end_line <= lhci_pkg::RST_COM_END;
      partial_start_line <= lhci_pkg::RST_PART_START;
      partial_end_line <= lhci_pkg::RST_PART_END;
    end else if (arg_take) begin
      case (arg_state)
        lhci_pkg::ARG_CONTRAST: contrast_value <= byte_val;
        lhci_pkg::ARG_COM_END: com_end_line <= byte_val[5:0];
        lhci_pkg::ARG_PART_START: partial_start_line <= byte_val[5:0];
        lhci_pkg::ARG_PART_END: partial_end_line <= byte_val[5:0];
        default: contrast_value <= contrast_value;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (any_reset) begin
      partial_enable <= 1'b0;
      addr_advance_ctrl <= lhci_pkg::RST_ADV;
      frame_rate_sel <= lhci_pkg::RST_FRAME;
      all_pixels_on <= 1'b0;
      invert_display <= 1'b0;
      display_on_not_powerdown <= 1'b0;
      com_mirror <= 1'b0;
      seg_mirror <= 1'b0;
      bias_ratio <= lhci_pkg::RST_BIAS;
      test_table_sel <= 1'b0;
    end else begin
      if (c_part)
        partial_enable <= byte_val[0];
      if (c_adv)
        addr_advance_ctrl <= byte_val[2:0];
      if (c_frame)
        frame_rate_sel <= byte_val[1:0];
      if (c_allon)
        all_pixels_on <= byte_val[0];
      if (c_inv)
        invert_display <= byte_val[0];
      if (c_disp)
        display_on_not_powerdown <= byte_val[0];
      if (c_scan) begin
        com_mirror <= byte_val[2];
        seg_mirror <= byte_val[1];
      end
      if (c_bias)
        bias_ratio <= byte_val[1:0];
      if (c_test)
        test_table_sel <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Outputs to RAM and pins
  // ----------------------------------------------------------------
  wire [7:0] next_oe = mode_par ? {8{par_rd_active}} : {4'h0, {3{sda_low}}, 1'b0};
  wire [7:0] next_out = mode_par ? rd_byte : 8'h00;

  always_ff @(posedge clk) begin
    if (reset) begin
      ram_wr_en <= 1'b0;
      ram_wr_data <= 8'h00;
      soft_reset_pulse <= 1'b0;
      data_out <= 8'h00;
      data_oe <= 8'h00;
    end else begin
      ram_wr_en <= data_wr;
      ram_wr_data <= byte_val;
      soft_reset_pulse <= c_srst;
      data_out <= next_out;
      data_oe <= next_oe;
    end
  end

endmodule

// ===== test/lhci_host_model.sv
// Purpose: Host processor model driving the controller's link pins.
// Assumes: Serial clock phases last 4 clk each, a 200 ns link period; strobes are active 6 clk, then idle 4 clk.
// Notes: Released data lines carry the inverse of their last value.
`timescale 1ns/1ps
module lhci_host_model (
  // Clock
  input wire logic clk,
  // Link pins
  output logic [2:0] mode,
  output logic cs_n,
  output logic sel,
  output logic rd,
  output logic wr,
  output logic [7:0] dq,
  input wire logic [7:0] data_out
);
  initial begin
    mode = lhci_pkg::MODE_PAR_STROBES;
    cs_n = 1'b1;
    sel = 1'b0;
    rd = 1'b1;
    wr = 1'b1;
    dq = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Straps change only while deselected, with the strobes parked idle.
  task automatic set_mode(input logic [2:0] m);
    cs_n <= 1'b1;
    dq <= 8'h00;
    rd <= (m != lhci_pkg::MODE_PAR_ENABLE);
    wr <= 1'b1;
    mode <= m;
    tick(8);
  endtask
  task automatic par_xfer(input logic rw, input logic s, input logic [7:0] b, input logic csl,
                          output logic [7:0] q);
    logic en;
    en = (mode == lhci_pkg::MODE_PAR_ENABLE);
    cs_n <= !csl;
    sel <= s;
    dq <= rw ? ~dq : b;
    wr <= rw;
    rd <= en | !rw;
    tick(6);
    q = data_out;
    rd <= !en;
    wr <= en ? rw : 1'b1;
    tick(4);
    cs_n <= 1'b1;
    dq <= ~dq;
    tick(1);
  endtask
  // The serial clock rests low between frames.
  task automatic spi_write(input logic s, input logic [7:0] b, input logic csl);
    cs_n <= !csl;
    sel <= s;
    for (int i = 7; i >= 0; i--) begin
      dq <= {3'h0, 1'b0, {3{b[i]}}, 1'b0};
      tick(4);
      dq[4] <= 1'b1;
      dq[0] <= 1'b1;
      tick(4);
    end
    dq <= {3'h0, 1'b0, {3{~b[0]}}, 1'b0};
    tick(4);
    cs_n <= 1'b1;
    tick(1);
  endtask
  // One byte per frame; the device's acknowledge is not fed back to the host.
  task automatic i2c_write(input logic s, input logic [7:0] b, input logic csl);
    logic [17:0] f;
    f = {lhci_pkg::I2C_ADDR, 1'b0, 1'b1, b, 1'b1};
    cs_n <= !csl;
    sel <= s;
    dq <= 8'h1F;
    tick(4);
    dq <= 8'h11;
    tick(4);
    for (int i = 17; i >= 0; i--) begin
      dq <= {3'h0, 1'b0, {3{f[i]}}, 1'b0};
      tick(4);
      dq[4] <= 1'b1;
      dq[0] <= 1'b1;
      tick(4);
    end
    dq <= 8'h00;
    tick(4);
    dq <= 8'h11;
    tick(4);
    dq <= 8'h1F;
    tick(4);
    cs_n <= 1'b1;
    tick(1);
  endtask
endmodule

// ===== test/lhci_top_asserts.sv
// Purpose: Port-level assertions for the host command interface.
// Assumes: One clock domain with synchronous active-high reset.
// Notes: Quiet checks count cycles of deselected chip select.
`timescale 1ns/1ps
module lhci_top_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Watched ports
  input wire logic bus_mode_sel_0,
  input wire logic bus_mode_sel_1,
  input wire logic bus_mode_sel_2,
  input wire logic chip_select_n,
  input wire logic [7:0] data_oe,
  input wire logic ram_wr_en,
  input wire logic [7:0] contrast_value,
  input wire logic [5:0] start_line,
  input wire logic test_table_sel,
  input wire logic soft_reset_pulse
);
  logic [3:0] desel;
  always_ff @(posedge clk) begin
    if (reset || !chip_select_n) begin
      desel <= 4'h0;
    end else if (desel != 4'hF) begin
      desel <= desel + 4'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_reset_defaults: assert property (disable iff (1'b0)
    reset |=> contrast_value == 8'h00 && data_oe == 8'h00 && !test_table_sel)
    else $error("Settings not at defaults after reset");
  a_wr_single: assert property (ram_wr_en |=> !ram_wr_en)
    else $error("RAM write strobe longer than one cycle");
  a_srst_single: assert property (soft_reset_pulse |=> !soft_reset_pulse [*4])
    else $error("Soft reset pulse repeated");
  a_srst_clears: assert property ($rose(soft_reset_pulse) |->
    ##[0:2] (!test_table_sel && contrast_value == 8'h00)) else $error("Soft reset left state");
  a_cs_quiet: assert property (desel > 4'h5 |->
    !ram_wr_en && !soft_reset_pulse && $stable(contrast_value)) else $error("Action while idle");
  a_spi_no_drive: assert property ({bus_mode_sel_2, bus_mode_sel_1, bus_mode_sel_0} ==
    lhci_pkg::MODE_SPI |-> data_oe == 8'h00) else $error("Data pins driven in serial mode");
  a_scroll_cause: assert property ($changed(start_line) |-> desel < 4'h6)
    else $error("Start line changed without access");
  a_read_drive: assert property (data_oe == 8'hFF |->
    desel < 4'h6 && bus_mode_sel_2 && bus_mode_sel_1) else $error("Bus driven outside read");
  c_write: cover property (ram_wr_en);
  c_read: cover property (data_oe == 8'hFF);
  c_test: cover property ($rose(test_table_sel));
endmodule
bind lhci_top lhci_top_asserts u_asserts (.clk(clk), .reset(reset),
  .bus_mode_sel_0(bus_mode_sel_0), .bus_mode_sel_1(bus_mode_sel_1),
  .bus_mode_sel_2(bus_mode_sel_2), .chip_select_n(chip_select_n), .data_oe(data_oe),
  .ram_wr_en(ram_wr_en), .contrast_value(contrast_value), .start_line(start_line),
  .test_table_sel(test_table_sel), .soft_reset_pulse(soft_reset_pulse));

// ===== test/lhci_top_tb.sv
// Purpose: Self-checking bench for the host command interface.
// Assumes: All four links are written; reads run on the two parallel styles.
// Notes: Settings are compared as one packed vector against a bench model.
`timescale 1ns/1ps
module lhci_top_tb;
  localparam logic [57:0] DEF = {18'h0, lhci_pkg::RST_CONTRAST, 1'h0, lhci_pkg::RST_ADV,
    lhci_pkg::RST_FRAME, 5'h0, lhci_pkg::RST_BIAS, lhci_pkg::RST_COM_END,
    lhci_pkg::RST_PART_START, lhci_pkg::RST_PART_END, 1'h0};
  logic clk, reset, cs_n, sel, rd, wr, f4, f3, wen, idx;
  logic [2:0] mode, arg;
  logic [7:0] dq, dout, rram, wdat, q, e, me, b;
  logic [15:0] t;
  logic [31:0] r;
  logic [57:0] ex;
  wire [57:0] st;
  logic [15:0] tab [19];
  logic [7:0] wr_q [$];
  int seed, fails, samples_checked;
  lhci_host_model u_host (.clk(clk), .mode(mode), .cs_n(cs_n), .sel(sel), .rd(rd), .wr(wr),
    .dq(dq), .data_out(dout));
  lhci_top u_dut (.clk(clk), .reset(reset), .bus_mode_sel_0(mode[0]),
    .bus_mode_sel_1(mode[1]), .bus_mode_sel_2(mode[2]), .chip_select_n(cs_n),
    .cmd_data_select(sel), .read_or_enable_strobe(rd), .write_or_direction_strobe(wr),
    .data_in(dq), .data_out(dout), .data_oe(), .status_flag_bit4(f4), .status_flag_bit3(f3),
    .ram_wr_en(wen), .ram_wr_data(wdat), .ram_rd_data(rram), .column_addr(st[57:50]),
    .page_addr(st[49:46]), .start_line(st[45:40]), .contrast_value(st[39:32]),
    .partial_enable(st[31]), .addr_advance_ctrl(st[30:28]), .frame_rate_sel(st[27:26]),
    .all_pixels_on(st[25]), .invert_display(st[24]), .display_on_not_powerdown(st[23]),
    .com_mirror(st[22]), .seg_mirror(st[21]), .bias_ratio(st[20:19]),
    .com_end_line(st[18:13]), .partial_start_line(st[12:7]), .partial_end_line(st[6:1]),
    .test_table_sel(st[0]), .soft_reset_pulse());
  task automatic chk_byte(input string n, input logic [7:0] x, input logic [7:0] g);
    samples_checked++;
    if (g !== x) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic chk_set();
    samples_checked++;
    if (st !== ex) begin
      fails++;
      $display("ERROR settings expected %h seen %h", ex, st);
    end
  endtask
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Bench model of the command set; the pins follow the model update.
  // ----------------------------------------------------------------
  task automatic send(input logic s, input logic [7:0] v);
    idx = 1'b0;
    if (s) begin
      wr_q.push_back(v);
      ex[57:50] = ex[57:50] + 8'h01;
    end else if (arg != 3'h0) begin
      if (arg == 3'h1) ex[39:32] = v;
      if (arg == 3'h2) ex[18:13] = v[5:0];
      if (arg == 3'h3) ex[12:7] = v[5:0];
      if (arg == 3'h4) ex[6:1] = v[5:0];
      arg = 3'h0;
    end else casez (v)
      8'b0000????: ex[53:50] = v[3:0];
      8'b0001????: ex[57:54] = v[3:0];
      8'b01??????: ex[45:40] = v[5:0];
      8'b1011????: ex[49:46] = v[3:0];
      8'h81: arg = 3'h1;
      8'b1000010?: ex[31] = v[0];
      8'b10001???: ex[30:28] = v[2:0];
      8'b101000??: ex[27:26] = v[1:0];
      8'b1010010?: ex[25] = v[0];
      8'b1010011?: ex[24] = v[0];
      8'b1010111?: ex[23] = v[0];
      8'b11000??0: ex[22:21] = v[2:1];
      8'b111010??: ex[20:19] = v[1:0];
      8'hE2: ex = DEF;
      8'hF0: ex[0] = 1'b1;
      8'hF1: arg = 3'h2;
      8'hF2: arg = 3'h3;
      8'hF3: arg = 3'h4;
      default: ;
    endcase
    if (mode == lhci_pkg::MODE_SPI) u_host.spi_write(s, v, 1'b1);
    else if (mode == lhci_pkg::MODE_I2C) u_host.i2c_write(s, v, 1'b1);
    else u_host.par_xfer(1'b0, s, v, 1'b1, q);
    u_host.tick(4);
  endtask
  task automatic read_chk(input logic s);
    r = $random(seed);
    {f4, f3} <= r[1:0];
    rram <= r[15:8];
    e = s ? r[15:8] : idx ? {6'h00, lhci_pkg::CHIP_ID[2:1]} :
      {lhci_pkg::CHIP_ID[0], ex[21], ex[22], r[1:0], 3'h0};
    u_host.par_xfer(1'b1, s, 8'h00, 1'b1, q);
    chk_byte("read byte", e, q);
    if (s) ex[57:50] = ex[57:50] + 8'h01;
    else idx = !idx;
    u_host.tick(4);
    chk_set();
  endtask
  always @(posedge clk) begin
    if (wen === 1'b1) begin
      me = (wr_q.size() != 0) ? wr_q.pop_front() : ~wdat;
      chk_byte("ram write", me, wdat);
    end
  end
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (90000) @(posedge clk);
    fails++;
    complete_run();
  end
  initial begin
    seed = 24701;
    reset = 1'b1;
    {f4, f3} = 2'h0;
    rram = 8'h00;
    ex = DEF;
    arg = 3'h0;
    idx = 1'b0;
    tab = '{16'h00F0, 16'h10F0, 16'h40C0, 16'hB0F0, 16'h81FF, 16'h84FE, 16'h88F8, 16'hA0FC,
      16'hA4FE, 16'hA6FE, 16'hAEFE, 16'hC0F9, 16'hE8FC, 16'hF1FF, 16'hF2FF, 16'hF3FF,
      16'hF0FF, 16'hE3FF, 16'hE2FF};
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    chk_set();
    for (int m = 0; m < 4; m++) begin
      u_host.set_mode(m == 0 ? lhci_pkg::MODE_PAR_STROBES : m == 1 ?
        lhci_pkg::MODE_PAR_ENABLE : m == 2 ? lhci_pkg::MODE_SPI : lhci_pkg::MODE_I2C);
      for (int i = 0; i < 38; i++) begin
        r = $random(seed);
        t = tab[i % 19];
        b = (t[15:8] & t[7:0]) | (r[7:0] & ~t[7:0]);
        send(1'b0, b);
        if (i % 3 == 0) send(1'b1, r[15:8]);
        if (arg != 3'h0) send(1'b0, r[23:16]);
        chk_set();
      end
      if (m < 2) begin
        read_chk(1'b0);
        read_chk(1'b0);
        read_chk(1'b0);
        read_chk(1'b1);
      end
      r = $random(seed);
      if (m == 3) u_host.i2c_write(1'b1, r[7:0], 1'b0);
      else if (m == 2) u_host.spi_write(1'b1, r[7:0], 1'b0);
      else u_host.par_xfer(1'b0, 1'b1, r[7:0], 1'b0, q);
      u_host.tick(4);
      chk_set();
      $display("Link test %0d done", m);
    end
    chk_byte("pending writes", 8'h00, 8'(wr_q.size()));
    complete_run();
  end
endmodule
